// *** src/gate_chk_pkg.sv ***
// constants and types shared by the system descriptor checker
package gate_chk_pkg;

	// register byte offsets on the apb bus
	localparam int AW = 8;
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_DESC_LO = 8'h04;
	localparam logic [AW-1:0] A_DESC_HI = 8'h08;
	localparam logic [AW-1:0] A_DEST_ACC = 8'h0c;
	localparam logic [AW-1:0] A_TASK_SEL = 8'h10;
	localparam logic [AW-1:0] A_RESULT = 8'h14;
	localparam logic [AW-1:0] A_TGT_SEL = 8'h18;
	localparam logic [AW-1:0] A_TGT_OFF = 8'h1c;
	localparam logic [AW-1:0] A_SEG_BASE = 8'h20;
	localparam logic [AW-1:0] A_SEG_LIMIT = 8'h24;
	localparam logic [AW-1:0] A_IRQ_STAT = 8'h28;
	localparam logic [AW-1:0] A_IRQ_MASK = 8'h2c;

	// control register bits
	localparam int C_START = 0;
	localparam int C_STACK32 = 1;
	localparam int C_IF = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// descriptor type codes
	localparam logic [3:0] T_TSEG16_AV = 4'h1;
	localparam logic [3:0] T_TSEG16_BUSY = 4'h3;
	localparam logic [3:0] T_TSEG32_AV = 4'h9;
	localparam logic [3:0] T_TSEG32_BUSY = 4'hb;
	localparam logic [3:0] T_CALL16 = 4'h4;
	localparam logic [3:0] T_TASK = 4'h5;
	localparam logic [3:0] T_INTR16 = 4'h6;
	localparam logic [3:0] T_TRAP16 = 4'h7;
	localparam logic [3:0] T_CALL32 = 4'hc;
	localparam logic [3:0] T_INTR32 = 4'he;
	localparam logic [3:0] T_TRAP32 = 4'hf;
	localparam int T_BUSY_BIT = 1;
	localparam int T_WIDE_BIT = 3;

	// exception vectors
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_NP = 8'h0b;
	localparam logic [7:0] EXC_GP = 8'h0d;

	// upper descriptor word fields
	localparam int HI_P = 15;
	localparam int HI_PRIV = 13;
	localparam int HI_S = 12;
	localparam int HI_TYPE = 8;
	localparam int HI_GRAN = 23;
	localparam int WC_W = 5;

	// access byte fields of the destination descriptor
	localparam int ACC_S = 4;
	localparam int ACC_E = 3;

	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int I_DONE = 0;
	localparam int I_NP = 1;
	localparam int I_GP = 2;

	typedef enum logic [2:0] {K_NONE, K_TSEG, K_CALL, K_TASK, K_INTR, K_TRAP} kind_t;

endpackage

// *** src/gate_checker.sv ***
// system and gate descriptor checker with apb register access
`timescale 1ns/1ns
`default_nettype none

module gate_checker
	import gate_chk_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// results toward the control transfer logic
	output logic chk_done,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	output logic [15:0] tgt_sel,
	output logic [31:0] tgt_off,
	output logic if_flag_out,
	output logic [WC_W-1:0] param_count,
	output logic param_unit32,
	output logic push32,
	output logic [1:0] gate_use_privilege,
	output logic [15:0] current_task_selector
);

	// register state
	logic [2:0] ctrl_r;
	logic [31:0] desc_lo_r;
	logic [31:0] desc_hi_r;
	logic [7:0] dest_acc_r;
	logic [15:0] current_task_selector_reg;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [IRQ_W-1:0] irq_set_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic pready_r;
	logic [31:0] prdata_r;

	// result state
	kind_t kind_r;
	logic wide_r;
	logic busy_r;
	logic fmt_wide_r;
	logic done_r;
	logic exc_r;
	logic [7:0] vec_r;
	logic [15:0] tsel_r;
	logic [31:0] toff_r;
	logic if_r;
	logic [WC_W-1:0] pcnt_r;
	logic unit32_r;
	logic push32_r;
	logic [1:0] priv_r;
	logic [31:0] base_r;
	logic [19:0] limit_r;
	logic gran_r;

	// apb decode; no wait state, and read data still leaves a flop
	wire setup_ph = psel & ~penable;
	wire xfer = psel & penable & pready_r;
	wire wr_en = xfer & pwrite;
	wire rd_en = xfer & ~pwrite;
	wire s_ctrl = (paddr == A_CTRL);
	wire s_lo = (paddr == A_DESC_LO);
	wire s_hi = (paddr == A_DESC_HI);
	wire s_acc = (paddr == A_DEST_ACC);
	wire s_task = (paddr == A_TASK_SEL);
	wire s_res = (paddr == A_RESULT);
	wire s_tsel = (paddr == A_TGT_SEL);
	wire s_toff = (paddr == A_TGT_OFF);
	wire s_base = (paddr == A_SEG_BASE);
	wire s_lim = (paddr == A_SEG_LIMIT);
	wire s_ist = (paddr == A_IRQ_STAT);
	wire s_imk = (paddr == A_IRQ_MASK);
	wire mapped = s_ctrl | s_lo | s_hi | s_acc | s_task | s_res | s_tsel
		| s_toff | s_base | s_lim | s_ist | s_imk;
	wire start_p = wr_en & s_ctrl & pwdata[C_START];

	// descriptor fields
	wire [3:0] d_type = desc_hi_r[HI_TYPE +: 4];
	wire d_p = desc_hi_r[HI_P];
	wire d_s = desc_hi_r[HI_S];
	wire [1:0] d_priv = desc_hi_r[HI_PRIV +: 2];
	wire [15:0] d_sel = desc_lo_r[31:16];
	wire [15:0] d_off_lo = desc_lo_r[15:0];
	wire [15:0] d_off_hi = desc_hi_r[31:16];
	wire [WC_W-1:0] d_wc = desc_hi_r[WC_W-1:0];

	// type decode
	wire is_tseg = (d_type == T_TSEG16_AV) | (d_type == T_TSEG16_BUSY)
		| (d_type == T_TSEG32_AV) | (d_type == T_TSEG32_BUSY);
	wire is_call = (d_type == T_CALL16) | (d_type == T_CALL32);
	wire is_task = (d_type == T_TASK);
	wire is_intr = (d_type == T_INTR16) | (d_type == T_INTR32);
	wire is_trap = (d_type == T_TRAP16) | (d_type == T_TRAP32);
	wire is_gate = is_call | is_task | is_intr | is_trap;
	wire type_wide = d_type[T_WIDE_BIT];

	// older format when the upper half of the upper word is all zero
	wire fmt_wide = |d_off_hi;

	// destination descriptor kind
	wire dest_code = dest_acc_r[ACC_S] & dest_acc_r[ACC_E];
	wire [3:0] dest_type = dest_acc_r[3:0];
	wire dest_tseg = ~dest_acc_r[ACC_S] & ((dest_type == T_TSEG16_AV)
		| (dest_type == T_TSEG16_BUSY) | (dest_type == T_TSEG32_AV)
		| (dest_type == T_TSEG32_BUSY));
	wire dest_ok = is_task ? dest_tseg : dest_code;

	// fault priority: bad type or system flag, then not present, then destination
	wire bad_kind = d_s | ~(is_gate | is_tseg);
	wire np_flt = ~bad_kind & is_gate & ~d_p;
	wire dst_flt = ~bad_kind & is_gate & d_p & ~dest_ok;
	wire any_flt = bad_kind | np_flt | dst_flt;
	wire [7:0] vec_c = np_flt ? EXC_NP : (any_flt ? EXC_GP : EXC_NONE);

	// kind code
	kind_t kind_c;
	assign kind_c = bad_kind ? K_NONE : is_tseg ? K_TSEG : is_call ? K_CALL
		: is_task ? K_TASK : is_intr ? K_INTR : K_TRAP;

	// pointer: wide gates carry a 32-bit offset, older ones 16
	wire [31:0] off_full = type_wide ? {d_off_hi, d_off_lo} : {16'h0000, d_off_lo};
	wire [31:0] toff_c = (is_call | is_intr | is_trap) ? off_full : 32'h0000_0000;

	// system segment base and limit; older form keeps 24/16 bits
	wire [31:0] base_c = fmt_wide ? {desc_hi_r[31:24], desc_hi_r[7:0], d_sel}
		: {8'h00, desc_hi_r[7:0], d_sel};
	wire [19:0] limit_c = fmt_wide ? {desc_hi_r[19:16], d_off_lo}
		: {4'h0, d_off_lo};

	// interrupt status events
	wire [IRQ_W-1:0] irq_set = {dst_flt | bad_kind, np_flt, 1'b1};
	wire [IRQ_W-1:0] irq_keep = (rd_en & s_ist) ? {IRQ_W{1'b0}} : irq_stat_r;

	// a hardware event in the clearing cycle stays set
	always_comb begin
		irq_stat_nxt = irq_keep;
		if (done_r)
			irq_stat_nxt = irq_keep | irq_set_r;
	end

	// read multiplexer; unmapped offsets read zero
	wire [31:0] res_word = {6'h00, vec_r, unit32_r, pcnt_r, priv_r, push32_r,
		if_r, exc_r, busy_r, wide_r, fmt_wide_r, gran_r, 3'(kind_r)};
	wire [31:0] rd_mux = s_ctrl ? {29'h0, ctrl_r}
		: s_lo ? desc_lo_r
		: s_hi ? desc_hi_r
		: s_acc ? {24'h0, dest_acc_r}
		: s_task ? {16'h0, current_task_selector_reg}
		: s_res ? res_word
		: s_tsel ? {16'h0, tsel_r}
		: s_toff ? toff_r
		: s_base ? base_r
		: s_lim ? {12'h0, limit_r}
		: s_ist ? {29'h0, irq_stat_r}
		: s_imk ? {29'h0, irq_mask_r}
		: 32'h0000_0000;

	// apb handshake and read data; the mux settles during setup, so the word
	// leaves a flop in the access cycle without any wait state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup_ph;
			prdata_r <= rd_mux;
		end
	end

	// software registers; start bit is a pulse and never stored
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
			desc_lo_r <= 32'h0000_0000;
			desc_hi_r <= 32'h0000_0000;
			dest_acc_r <= 8'h00;
			current_task_selector_reg <= 16'h0000;
			irq_mask_r <= {IRQ_W{1'b0}};
		end else if (wr_en) begin
			if (s_ctrl)
				ctrl_r <= {pwdata[C_IF], pwdata[C_STACK32], 1'b0};
			if (s_lo)
				desc_lo_r <= pwdata;
			if (s_hi)
				desc_hi_r <= pwdata;
			if (s_acc)
				dest_acc_r <= pwdata[7:0];
			if (s_task)
				current_task_selector_reg <= pwdata[15:0];
			if (s_imk)
				irq_mask_r <= pwdata[IRQ_W-1:0];
		end
	end

	// interrupt status, cleared by reading it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= {IRQ_W{1'b0}};
			irq_set_r <= {IRQ_W{1'b0}};
			done_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			done_r <= start_p;
			irq_set_r <= start_p ? irq_set : {IRQ_W{1'b0}};
		end
	end

	// check result, captured on the start pulse using the new control bits
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			kind_r <= K_NONE;
			wide_r <= 1'b0;
			busy_r <= 1'b0;
			fmt_wide_r <= 1'b0;
			exc_r <= 1'b0;
			vec_r <= EXC_NONE;
			tsel_r <= 16'h0000;
			toff_r <= 32'h0000_0000;
			if_r <= 1'b0;
			pcnt_r <= '0;
			unit32_r <= 1'b0;
			push32_r <= 1'b0;
			priv_r <= 2'h0;
			base_r <= 32'h0000_0000;
			limit_r <= 20'h00000;
			gran_r <= 1'b0;
		end else if (start_p) begin
			kind_r <= kind_c;
			wide_r <= type_wide;
			busy_r <= is_tseg & d_type[T_BUSY_BIT];
			fmt_wide_r <= fmt_wide;
			exc_r <= any_flt;
			vec_r <= vec_c;
			tsel_r <= d_sel;
			toff_r <= toff_c;
			if_r <= pwdata[C_IF] & ~is_intr;
			pcnt_r <= is_call ? d_wc : '0;
			unit32_r <= is_call & type_wide;
			push32_r <= is_call & pwdata[C_STACK32];
			priv_r <= d_priv;
			base_r <= base_c;
			limit_r <= limit_c;
			gran_r <= fmt_wide & desc_hi_r[HI_GRAN];
		end
	end

	// output drive
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = xfer & ~mapped;
	assign irq = |(irq_stat_r & irq_mask_r);
	assign chk_done = done_r;
	assign exc_valid = exc_r;
	assign exc_vector = vec_r;
	assign tgt_sel = tsel_r;
	assign tgt_off = toff_r;
	assign if_flag_out = if_r;
	assign param_count = pcnt_r;
	assign param_unit32 = unit32_r;
	assign push32 = push32_r;
	assign gate_use_privilege = priv_r;
	assign current_task_selector = current_task_selector_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// guards on the decode, the capture and the status clear by read
	tseg_busy_a: assert property (start_p && is_tseg && !d_s |=> kind_r == K_TSEG
		&& busy_r == $past(d_type[T_BUSY_BIT]))
		else $error("task segment class wrong");
	call_kind_a: assert property (start_p && !d_s && (d_type == T_CALL16 || d_type == T_CALL32)
		|=> kind_r == K_CALL)
		else $error("call gate not decoded");
	intr_kind_a: assert property (start_p && !d_s && d_type == T_INTR16 |=> kind_r == K_INTR)
		else $error("older interrupt gate not decoded");
	np_fault_a: assert property (start_p && !d_s && is_gate && !d_p |=> exc_valid && exc_vector == EXC_NP)
		else $error("missing vector 11");
	dest_fault_a: assert property (start_p && !d_s && is_task && d_p && !dest_tseg |=> exc_vector == EXC_GP)
		else $error("missing vector 13");
	sys_flag_a: assert property (start_p && d_s |=> exc_valid && exc_vector == EXC_GP && kind_r == K_NONE)
		else $error("system flag not enforced");
	intr_if_a: assert property (start_p && is_intr |=> !if_flag_out)
		else $error("interrupt gate kept the flag");
	trap_if_a: assert property (start_p && is_trap |=> if_flag_out == $past(pwdata[C_IF]))
		else $error("trap gate changed the flag");
	task_off_a: assert property (start_p && is_task |=> tgt_off == 32'h0000_0000 && tgt_sel == $past(d_sel))
		else $error("task gate offset used");
	param_zero_a: assert property (start_p && !is_call |=> param_count == '0 && !push32)
		else $error("count on non-call gate");
	old_fmt_a: assert property (start_p && d_off_hi == 16'h0000 |=> !fmt_wide_r && base_r[31:24] == 8'h00)
		else $error("older format misread");
	irq_clear_a: assert property (rd_en && s_ist && !done_r |=> irq_stat_r == '0)
		else $error("status not cleared by read");

	// guards on kinds, faults, flags, pointers, counts, privilege and formats; each looks at the
	// result captured one cycle after the start pulse
	tseg_fault_a: assert property (start_p && !d_s && is_tseg |=> !exc_valid)
		else $error("task segment flagged as a fault");
	tseg_wide_a: assert property (start_p && !d_s && is_tseg |=> wide_r == $past(d_type[T_WIDE_BIT]))
		else $error("task segment format misread");
	tseg_avail_a: assert property (start_p && !d_s && is_tseg && !d_type[T_BUSY_BIT] |=> !busy_r)
		else $error("available task segment marked busy");
	task_kind_a: assert property (start_p && !d_s && d_type == T_TASK |=> kind_r == K_TASK)
		else $error("task gate not decoded");
	trap_kind_a: assert property (start_p && !d_s && (d_type == T_TRAP16 || d_type == T_TRAP32)
		|=> kind_r == K_TRAP)
		else $error("trap gate not decoded");
	wide_intr_a: assert property (start_p && !d_s && d_type == T_INTR32 |=> kind_r == K_INTR)
		else $error("wide interrupt gate not decoded");
	gate_valid_a: assert property (start_p && !d_s && is_gate && d_p && dest_ok |=> !exc_valid)
		else $error("valid gate raised a fault");
	code_dest_a: assert property (start_p && !d_s && !is_task && is_gate && d_p && !dest_code
		|=> exc_valid && exc_vector == EXC_GP)
		else $error("gate to non-code destination accepted");
	call_if_a: assert property (start_p && is_call |=> if_flag_out == $past(pwdata[C_IF]))
		else $error("call gate changed the flag");
	handler_ptr_a: assert property (start_p && (is_intr || is_trap)
		|=> tgt_sel == $past(d_sel) && tgt_off[15:0] == $past(d_off_lo))
		else $error("handler pointer wrong");
	wide_off_a: assert property (start_p && !is_task && is_gate && type_wide
		|=> tgt_off[31:16] == $past(d_off_hi))
		else $error("wide gate offset high half lost");
	old_off_a: assert property (start_p && !type_wide |=> tgt_off[31:16] == 16'h0000)
		else $error("older gate offset above 16 bits");
	call_ptr_a: assert property (start_p && is_call
		|=> tgt_sel == $past(d_sel) && tgt_off[15:0] == $past(d_off_lo))
		else $error("call gate entry point wrong");
	call_count_a: assert property (start_p && is_call |=> param_count == $past(d_wc))
		else $error("call gate count wrong");
	gate_sys_a: assert property (start_p && is_gate && !d_s |=> kind_r != K_NONE)
		else $error("system gate refused");
	gate_priv_a: assert property (start_p |=> gate_use_privilege == $past(d_priv))
		else $error("gate privilege not passed on");
	old_limit_a: assert property (start_p && d_off_hi == 16'h0000 |=> limit_r[19:16] == 4'h0 && !gran_r)
		else $error("older limit wider than 16 bits");
	wide_base_a: assert property (start_p && d_off_hi != 16'h0000
		|=> fmt_wide_r && base_r[31:24] == $past(desc_hi_r[31:24]))
		else $error("wide base high byte lost");
	unit_size_a: assert property (start_p && is_call |=> param_unit32 == $past(type_wide))
		else $error("call count unit wrong");
	push_size_a: assert property (start_p && is_call |=> push32 == $past(pwdata[C_STACK32]))
		else $error("call push width wrong");

	// register and status guards
	task_sel_a: assert property (wr_en && s_task |=> current_task_selector == $past(pwdata[15:0]))
		else $error("current task selector not loaded");
	status_set_a: assert property (done_r |=> (irq_stat_r & $past(irq_set_r)) == $past(irq_set_r))
		else $error("status event lost");

endmodule

`default_nettype wire

// *** sim/desc_table.sv ***
// descriptor table model: one gate or task segment entry for each type code
`timescale 1ns/1ns
`default_nettype none

module desc_table
	import gate_chk_pkg::*;
(
	// entry select
	input wire logic [3:0] idx,
	// entry words and the access byte of the entry's destination
	output logic [31:0] lo,
	output logic [31:0] hi,
	output logic [7:0] acc
);
	// every entry is present, privilege 2, five parameters, selector 1234, offset 9abc5678
	assign lo = 32'h1234_5678;
	assign hi = {16'h9abc, 1'b1, 2'h2, 1'b0, idx, 3'h0, 5'h05};
	// a task gate points at an available task segment, every other gate at code
	assign acc = (idx == T_TASK) ? 8'h89 : 8'h9a;
endmodule

`default_nettype wire

// *** sim/gate_checker_test.sv ***
// self-checking bench for the system descriptor checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module gate_checker_test
	import gate_chk_pkg::*;
;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, chk_done, exc_valid, if_flag_out;
	logic param_unit32, push32, err;
	logic [7:0] paddr, exc_vector, acc;
	logic [31:0] pwdata, prdata, tgt_off, q, lo, hi;
	logic [15:0] tgt_sel, current_task_selector;
	logic [WC_W-1:0] param_count;
	logic [1:0] gate_use_privilege;
	logic [3:0] idx, t;
	int fails = 0;
	int n_tests = 0;
	logic [3:0] types [11] = '{4'h1, 4'h3, 4'h9, 4'hb, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};

	gate_checker DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.chk_done(chk_done), .exc_valid(exc_valid), .exc_vector(exc_vector), .tgt_sel(tgt_sel),
		.tgt_off(tgt_off), .if_flag_out(if_flag_out), .param_count(param_count), .param_unit32(param_unit32),
		.push32(push32), .gate_use_privilege(gate_use_privilege), .current_task_selector(current_task_selector));
	desc_table mem (.idx(idx), .lo(lo), .hi(hi), .acc(acc));

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one apb transfer; the request stands until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			fails++;
			complete_run();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// load a descriptor, start a check, wait for the done pulse, read the result word
	task automatic run(input logic [31:0] l, input logic [31:0] h, input logic [7:0] a, input logic [2:0] c);
		int i;
		apb(1'b1, A_DESC_LO, l);
		apb(1'b1, A_DESC_HI, h);
		apb(1'b1, A_DEST_ACC, {24'h0, a});
		apb(1'b1, A_CTRL, {29'h0, c | 3'h1});
		for (i = 0; i < 8; i++) begin
			if (chk_done === 1'b1) break;
			@(posedge clock);
		end
		if (i == 8) begin
			fails++;
			complete_run();
		end
		apb(1'b0, A_RESULT, 32'h0);
	endtask

	function automatic logic [31:0] hiw(input logic p, input logic s, input logic [3:0] ty);
		hiw = {16'h9abc, p, 2'h2, s, ty, 3'h0, 5'h05};
	endfunction

	function automatic logic [2:0] kind_of(input logic [3:0] ty);
		case (ty)
			4'h1, 4'h3, 4'h9, 4'hb: kind_of = K_TSEG;
			4'h4, 4'hc: kind_of = K_CALL;
			4'h5: kind_of = K_TASK;
			4'h6, 4'he: kind_of = K_INTR;
			4'h7, 4'hf: kind_of = K_TRAP;
			default: kind_of = K_NONE;
		endcase
	endfunction

	task automatic fault(input logic [31:0] h, input logic [7:0] a, input logic [7:0] v);
		run(32'h1234_5678, h, a, 3'h0);
		`CHK({exc_valid, exc_vector}, {1'b1, v})
		`CHK(q[25:18], v)
	endtask

	// base and limit come from different fields in the two formats
	task automatic seg(input logic [31:0] h, input logic [1:0] f, input logic [31:0] b, input logic [19:0] l);
		run(32'h1234_5678, h, 8'h0, 3'h0);
		`CHK(q[4:3], f)
		apb(1'b0, A_SEG_BASE, 32'h0);
		`CHK(q, b)
		apb(1'b0, A_SEG_LIMIT, 32'h0);
		`CHK(q[19:0], l)
	endtask

	// main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		idx = 4'h0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		`CHK({exc_valid, irq, current_task_selector}, 18'h0)
		apb(1'b1, A_TASK_SEL, 32'h0000_5a5a);
		apb(1'b0, A_TASK_SEL, 32'h0);
		`CHK({q[15:0], current_task_selector}, 32'h5a5a_5a5a)
		apb(1'b0, 8'hfc, 32'h0);
		`CHK({err, q}, 33'h1_0000_0000)
		// every type code with a matching destination, interrupt flag in 1, wide stack
		foreach (types[k]) begin
			idx = types[k];
			t = types[k];
			#1;
			run(lo, hi, acc, 3'h6);
			`CHK(q[2:0], kind_of(t))
			`CHK(exc_valid, 1'b0)
			if (kind_of(t) == K_TSEG) begin
				`CHK(q[6:5], {t[1], t[3]})
			end else begin
				`CHK(gate_use_privilege, 2'h2)
				`CHK(tgt_sel, 16'h1234)
				`CHK(tgt_off, (t == T_TASK) ? 32'h0 : (t[3] ? 32'h9abc_5678 : 32'h5678))
				`CHK(param_count, (kind_of(t) == K_CALL) ? 5'h05 : 5'h00)
				`CHK({param_unit32, push32}, {t == T_CALL32, kind_of(t) == K_CALL})
				`CHK(if_flag_out, kind_of(t) != K_INTR)
			end
		end
		idx = T_CALL16;
		#1;
		run(lo, hi, acc, 3'h0);
		`CHK({param_unit32, push32}, 2'h0)
		`CHK(if_flag_out, 1'b0)
		fault(hiw(1'b0, 1'b0, T_INTR32), 8'h9a, EXC_NP);
		fault(hiw(1'b1, 1'b1, T_CALL32), 8'h9a, EXC_GP);
		fault(hiw(1'b1, 1'b0, T_INTR32), 8'h92, EXC_GP);
		fault(hiw(1'b1, 1'b0, T_TASK), 8'h9a, EXC_GP);
		seg(32'h0000_8156, 2'h0, 32'h0056_1234, 20'h05678);
		seg(32'hab8f_8956, 2'h3, 32'hab56_1234, 20'hf5678);
		// masked event leaves irq low; unmasking raises it, a status read drops it
		apb(1'b0, A_IRQ_STAT, 32'h0);
		apb(1'b1, A_IRQ_MASK, 32'h4);
		fault(hiw(1'b0, 1'b0, T_TRAP32), 8'h9a, EXC_NP);
		`CHK(irq, 1'b0)
		apb(1'b1, A_IRQ_MASK, 32'h2);
		apb(1'b0, A_IRQ_MASK, 32'h0);
		`CHK({irq, q[2:0]}, 4'ha)
		apb(1'b0, A_IRQ_STAT, 32'h0);
		`CHK(q[2:0], 3'h3)
		apb(1'b0, A_IRQ_STAT, 32'h0);
		`CHK({irq, q[2:0]}, 4'h0)
		complete_run();
	end
endmodule

`default_nettype wire
